/* File: common/rcc_pkg.sv */
package rcc_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFS_CLK_CTRL = 12'h000;
  localparam logic [11:0] OFS_CLK_CFG = 12'h004;
  localparam logic [11:0] OFS_CLK_IRQ = 12'h008;
  localparam logic [11:0] OFS_CTRL_STAT = 12'h00C;
  localparam logic [11:0] OFS_BKP_CTRL = 12'h010;
  // Clock control fields.
  localparam int B_RC_ON = 0;
  localparam int B_RC_RDY = 1;
  localparam int B_OSC_ON = 16;
  localparam int B_OSC_RDY = 17;
  localparam int B_OSC_BYP = 18;
  localparam int B_PLL_ON = 24;
  localparam int B_PLL_RDY = 25;
  // Clock configuration fields, each two bits wide.
  localparam int F_SW = 0;
  localparam int F_SWS = 2;
  localparam int F_AHB = 4;
  localparam int F_LOW_SPEED_APB = 8;
  localparam int F_HIGH_SPEED_APB = 11;
  localparam int F_ADC = 14;
  // Clock interrupt fields.
  localparam int B_OSC_RDYF = 3;
  localparam int B_OSC_RDYIE = 11;
  localparam int B_OSC_RDYC = 19;
  // Control/status fields; flags sit at B_FLAGS upward.
  localparam int B_SLOW_RC_ON = 0;
  localparam int B_SLOW_RC_RDY = 1;
  localparam int B_RMVF = 24;
  localparam int B_FLAGS = 26;
  localparam int FL_PIN = 0;
  localparam int FL_POR = 1;
  localparam int FL_SW = 2;
  localparam int FL_INDEPENDENT_WATCHDOG = 3;
  localparam int FL_WINDOW_WATCHDOG = 4;
  localparam int FL_LPWR = 5;
  // Backup control fields.
  localparam int B_XTAL_ON = 0;
  localparam int B_XTAL_RDY = 1;
  localparam int F_RTC_SEL = 8;
  localparam int B_BD_RST = 16;
  // System clock source codes.
  localparam logic [1:0] SRC_FAST_RC = 2'h0;
  localparam logic [1:0] SRC_FAST_OSC = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0004;
  // Reset pulse timing.
  localparam int CLK_HZ = 10_000_000;
  localparam int RST_PULSE_US = 20;
  localparam int RST_CYC = (RST_PULSE_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);
  localparam int SYSTEM_TICK_TIMER_DIV = 8;
  // Synchronised pin inputs.
  localparam int NSYNC = 9;
  localparam int S_PIN = 0;
  localparam int S_STBY_OPT = 1;
  localparam int S_STOP_OPT = 2;
  localparam int S_POR = 3;
  localparam int S_STBY_EXIT = 4;
  localparam int S_OSC_OK = 5;
  localparam int S_RC_OK = 6;
  localparam int S_SLOW_RC_OK = 7;
  localparam int S_XTAL_OK = 8;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic ahb;
    logic low_speed_apb;
    logic high_speed_apb;
    logic tim1;
    logic tim2;
    logic system_tick_timer;
    logic adc;
  } ticks_t;
endpackage : rcc_pkg

/* File: rtl/rcc_ctrl.sv */
// Operation
// - System reset restores registers except reset flags and backup domain.
// - Pin, both watchdogs, software request, low-power reset raise system reset.
// - Reset cause is recorded in control/status flags for software.
// - Core software reset request performs a system reset.
// - Cleared stop/standby option turns mode entry into a reset.
// - Power detect or standby exit gives power reset, backup kept.
// - Internal resets drive the reset pin low during the delay.
// - Internal reset pulse lasts 20 us; external one while pin low.
// - Reset handler vector is fetched from address 0x0000_0004.
// - Backup domain resets alone on its software bit or supply loss.
// - System clock chooses fast RC, fast oscillator or PLL only.
// - Slow RC feeds watchdog and optional RTC; slow crystal optional.
// - Every clock source has its own on/off control.
// - Prescalers derive AHB and both APB clocks, none above 24 MHz.
// - System tick reference is AHB clock divided by eight.
// - Converter clock is fast APB divided by 2, 4, 6 or 8.
// - Flash interface clock always comes from the fast RC.
// - APB timer clock equals APB clock at prescale 1, else double.
// - Bypass mode sets bypass and enable; pin driven externally.
// - Oscillator ready flag set when stable; clock gated until then.
// - Oscillator ready raises an interrupt when enabled.
// - Oscillator starts and stops with its enable bit.
// - Any system reset selects the fast RC as system clock.
// - Clock switch waits until the target source is ready.
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl
  import rcc_pkg::*;
(
  // Clock and power-on reset.
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Register bus.
  input wire apb_req_t i_apb,
  output apb_rsp_t o_apb,
  // External reset pin, open drain.
  input wire logic i_ext_reset_pin_n,
  output logic o_ext_reset_pin_n_o,
  output logic o_ext_reset_pin_n_oe,
  // Reset sources on the system clock.
  input wire logic i_window_watchdog_rst,
  input wire logic i_independent_watchdog_rst,
  input wire logic i_core_sw_reset_request,
  input wire logic i_stop_entry,
  input wire logic i_standby_entry,
  // Reset sources and straps from outside the clock domain.
  input wire logic i_standby_reset_option,
  input wire logic i_stop_reset_option,
  input wire logic i_power_on_down_detect,
  input wire logic i_standby_exit,
  input wire logic i_backup_power_lost,
  // Oscillator status.
  input wire logic i_fast_osc_stable,
  input wire logic i_fast_rc_stable,
  input wire logic i_pll_lock,
  input wire logic i_slow_rc_stable,
  input wire logic i_slow_crystal_stable,
  // Reset outputs.
  output logic o_sys_reset_n,
  output logic o_backup_reset_n,
  output logic [31:0] o_reset_vector,
  output logic o_enter_stop,
  output logic o_enter_standby,
  // Clock source controls.
  output logic o_fast_rc_enable,
  output logic o_fast_osc_enable,
  output logic o_fast_osc_bypass,
  output logic o_fast_osc_release,
  output logic o_pll_enable,
  output logic o_slow_rc_enable,
  output logic o_slow_crystal_enable,
  output logic [1:0] o_rtc_clock_sel,
  output logic [1:0] o_system_clock_sel,
  output logic o_flash_iface_clock_en,
  output ticks_t o_ticks,
  output logic o_clock_irq
);

  typedef enum logic [1:0] {RS_RUN, RS_PULSE, RS_PIN} rst_t;

  typedef struct packed {
    logic [NSYNC-1:0] sa;
    logic [NSYNC-1:0] sb;
    logic bkp_lost_a;
    logic bkp_lost_b;
    rst_t rst;
    logic [7:0] rcnt;
    logic [5:0] flags;
    logic rc_on;
    logic osc_on;
    logic osc_byp;
    logic pll_on;
    logic [1:0] sw;
    logic [1:0] sws;
    logic [1:0] ahb;
    logic [1:0] low_speed_apb;
    logic [1:0] high_speed_apb;
    logic [1:0] adc;
    logic osc_rdyf;
    logic osc_rdyie;
    logic osc_rdy_prev;
    logic slow_rc_on;
    logic xtal_on;
    logic [1:0] rtc_sel;
    logic bd_rst;
    logic bkp_rst_n;
    logic [2:0] ahb_c;
    logic [2:0] a1_c;
    logic [2:0] a2_c;
    logic [2:0] st_c;
    logic [2:0] adc_c;
    ticks_t tk;
    apb_rsp_t rsp;
    logic sys_rst_n;
    logic pin_oe;
    logic irq;
    logic ent_stop;
    logic ent_stby;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [NSYNC-1:0] async_in;
  logic rc_rdy;
  logic osc_rdy;
  logic pll_rdy;
  logic [2:0] src_rdy;
  logic pin_low;
  logic power_src;
  logic [5:0] sys_src;
  logic [31:0] rd;
  logic hit;
  logic wr;

  assign async_in = {i_slow_crystal_stable, i_slow_rc_stable, i_fast_rc_stable,
                     i_fast_osc_stable, i_standby_exit, i_power_on_down_detect,
                     i_stop_reset_option, i_standby_reset_option, i_ext_reset_pin_n};

  // A ready flag needs both the enable and the settled analog indication.
  assign rc_rdy = st_q.rc_on & st_q.sb[S_RC_OK];
  assign osc_rdy = st_q.osc_on & st_q.sb[S_OSC_OK];
  assign pll_rdy = st_q.pll_on & i_pll_lock;
  assign src_rdy = {pll_rdy, osc_rdy, rc_rdy};
  assign pin_low = ~st_q.sb[S_PIN];
  assign power_src = st_q.sb[S_POR] | st_q.sb[S_STBY_EXIT];
  always_comb begin
    sys_src = '0;
    sys_src[FL_SW] = i_core_sw_reset_request;
    sys_src[FL_INDEPENDENT_WATCHDOG] = i_independent_watchdog_rst;
    sys_src[FL_WINDOW_WATCHDOG] = i_window_watchdog_rst;
    sys_src[FL_LPWR] = (i_stop_entry & ~st_q.sb[S_STOP_OPT]) |
                       (i_standby_entry & ~st_q.sb[S_STBY_OPT]);
  end

  always_comb begin
    rd = '0;
    hit = 1'b1;
    case (i_apb.paddr)
      OFS_CLK_CTRL: begin
        rd[B_RC_ON] = st_q.rc_on;
        rd[B_RC_RDY] = rc_rdy;
        rd[B_OSC_ON] = st_q.osc_on;
        rd[B_OSC_RDY] = osc_rdy;
        rd[B_OSC_BYP] = st_q.osc_byp;
        rd[B_PLL_ON] = st_q.pll_on;
        rd[B_PLL_RDY] = pll_rdy;
      end
      OFS_CLK_CFG: begin
        rd[F_SW+:2] = st_q.sw;
        rd[F_SWS+:2] = st_q.sws;
        rd[F_AHB+:2] = st_q.ahb;
        rd[F_LOW_SPEED_APB+:2] = st_q.low_speed_apb;
        rd[F_HIGH_SPEED_APB+:2] = st_q.high_speed_apb;
        rd[F_ADC+:2] = st_q.adc;
      end
      OFS_CLK_IRQ: begin
        rd[B_OSC_RDYF] = st_q.osc_rdyf;
        rd[B_OSC_RDYIE] = st_q.osc_rdyie;
      end
      OFS_CTRL_STAT: begin
        rd[B_SLOW_RC_ON] = st_q.slow_rc_on;
        rd[B_SLOW_RC_RDY] = st_q.slow_rc_on & st_q.sb[S_SLOW_RC_OK];
        rd[B_FLAGS+:6] = st_q.flags;
      end
      OFS_BKP_CTRL: begin
        rd[B_XTAL_ON] = st_q.xtal_on;
        rd[B_XTAL_RDY] = st_q.xtal_on & st_q.sb[S_XTAL_OK];
        rd[F_RTC_SEL+:2] = st_q.rtc_sel;
        rd[B_BD_RST] = st_q.bd_rst;
      end
      default: hit = 1'b0;
    endcase
  end

  // Writes land at the edge where the access phase meets pready.
  assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite & st_q.rsp.pready & hit;

  always_comb begin
    st_d = st_q;
    st_d.sa = async_in;
    st_d.sb = st_q.sa;
    st_d.bkp_lost_a = i_backup_power_lost;
    st_d.bkp_lost_b = st_q.bkp_lost_a;
    st_d.ent_stop = i_stop_entry & st_q.sb[S_STOP_OPT];
    st_d.ent_stby = i_standby_entry & st_q.sb[S_STBY_OPT];

    // Zero-wait slave: pready rises in the access phase's first cycle.
    st_d.rsp.pready = i_apb.psel & ~i_apb.penable;
    st_d.rsp.pslverr = i_apb.psel & ~i_apb.penable & ~hit;
    if (i_apb.psel & ~i_apb.penable) begin
      st_d.rsp.prdata = rd;
    end

    if (wr) begin
      case (i_apb.paddr)
        OFS_CLK_CTRL: begin
          st_d.rc_on = i_apb.pwdata[B_RC_ON];
          st_d.osc_on = i_apb.pwdata[B_OSC_ON];
          st_d.osc_byp = i_apb.pwdata[B_OSC_BYP];
          st_d.pll_on = i_apb.pwdata[B_PLL_ON];
        end
        OFS_CLK_CFG: begin
          st_d.sw = i_apb.pwdata[F_SW+:2];
          st_d.ahb = i_apb.pwdata[F_AHB+:2];
          st_d.low_speed_apb = i_apb.pwdata[F_LOW_SPEED_APB+:2];
          st_d.high_speed_apb = i_apb.pwdata[F_HIGH_SPEED_APB+:2];
          st_d.adc = i_apb.pwdata[F_ADC+:2];
        end
        OFS_CLK_IRQ: begin
          st_d.osc_rdyie = i_apb.pwdata[B_OSC_RDYIE];
          if (i_apb.pwdata[B_OSC_RDYC]) begin
            st_d.osc_rdyf = 1'b0;
          end
        end
        OFS_CTRL_STAT: begin
          st_d.slow_rc_on = i_apb.pwdata[B_SLOW_RC_ON];
          if (i_apb.pwdata[B_RMVF]) begin
            st_d.flags = '0;
          end
        end
        OFS_BKP_CTRL: begin
          st_d.xtal_on = i_apb.pwdata[B_XTAL_ON];
          st_d.rtc_sel = i_apb.pwdata[F_RTC_SEL+:2];
          st_d.bd_rst = i_apb.pwdata[B_BD_RST];
        end
        default: ;
      endcase
    end
    // The ready event is applied after the clear so that it wins.
    st_d.osc_rdy_prev = osc_rdy;
    if (osc_rdy & ~st_q.osc_rdy_prev) begin
      st_d.osc_rdyf = 1'b1;
    end
    st_d.irq = st_d.osc_rdyf & st_d.osc_rdyie;

    // Switch only to a ready source; an unready request stays pending.
    if (st_q.sw != 2'h3 && src_rdy[st_q.sw]) begin
      st_d.sws = st_q.sw;
    end
    // A source in use cannot be stopped; testing the next source covers a write in the switch cycle.
    if (st_d.sws == SRC_FAST_RC) begin
      st_d.rc_on = 1'b1;
    end
    if (st_d.sws == SRC_FAST_OSC) begin
      st_d.osc_on = 1'b1;
    end
    if (st_d.sws == SRC_PLL) begin
      st_d.pll_on = 1'b1;
    end

    // Divider chain in system clock cycles; sources stay at or below 24 MHz.
    st_d.tk = '0;
    st_d.ahb_c = st_q.ahb_c + 3'h1;
    if (st_q.ahb_c >= 3'((4'h1 << st_q.ahb) - 4'h1)) begin
      st_d.ahb_c = '0;
      st_d.tk.ahb = 1'b1;
    end
    if (st_d.tk.ahb) begin
      st_d.a1_c = st_q.a1_c + 3'h1;
      st_d.a2_c = st_q.a2_c + 3'h1;
      st_d.st_c = st_q.st_c + 3'h1;
      if (st_q.a1_c >= 3'((4'h1 << st_q.low_speed_apb) - 4'h1)) begin
        st_d.a1_c = '0;
        st_d.tk.low_speed_apb = 1'b1;
      end
      if (st_q.a2_c >= 3'((4'h1 << st_q.high_speed_apb) - 4'h1)) begin
        st_d.a2_c = '0;
        st_d.tk.high_speed_apb = 1'b1;
      end
      // Above prescale 1, timer ticks land on both the wrap and the half point, doubling the rate.
      st_d.tk.tim1 = st_d.tk.low_speed_apb |
        ((st_q.low_speed_apb != 2'h0) && st_q.a1_c == 3'((4'h1 << st_q.low_speed_apb) / 4'h2 - 4'h1));
      st_d.tk.tim2 = st_d.tk.high_speed_apb |
        ((st_q.high_speed_apb != 2'h0) && st_q.a2_c == 3'((4'h1 << st_q.high_speed_apb) / 4'h2 - 4'h1));
      if (st_q.st_c == 3'(SYSTEM_TICK_TIMER_DIV - 1)) begin
        st_d.st_c = '0;
        st_d.tk.system_tick_timer = 1'b1;
      end
    end
    if (st_d.tk.high_speed_apb) begin
      st_d.adc_c = st_q.adc_c + 3'h1;
      if (st_q.adc_c >= {st_q.adc, 1'b1}) begin
        st_d.adc_c = '0;
        st_d.tk.adc = 1'b1;
      end
    end

    // Reset sequencer.
    case (st_q.rst)
      RS_RUN: begin
        if (power_src) begin
          st_d.flags = '0;
          st_d.flags[FL_POR] = 1'b1;
          st_d.rst = RS_PULSE;
          st_d.rcnt = '0;
        end else if (|sys_src) begin
          st_d.flags = st_d.flags | sys_src;
          st_d.rst = RS_PULSE;
          st_d.rcnt = '0;
        end else if (pin_low) begin
          st_d.flags[FL_PIN] = 1'b1;
          st_d.rst = RS_PIN;
        end
      end
      RS_PULSE: begin
        st_d.rcnt = st_q.rcnt + 8'h01;
        if (st_q.rcnt == RST_LAST && !power_src) begin
          st_d.rst = RS_PIN;
        end
      end
      RS_PIN: begin
        if (!pin_low) begin
          st_d.rst = RS_RUN;
        end
      end
      default: st_d.rst = RS_RUN;
    endcase
    st_d.pin_oe = (st_d.rst == RS_PULSE);
    st_d.sys_rst_n = (st_d.rst == RS_RUN);

    if (st_d.rst != RS_RUN) begin
      // Flags, backup fields and the bus answer survive a system reset.
      st_d.rc_on = 1'b1;
      st_d.osc_on = 1'b0;
      st_d.osc_byp = 1'b0;
      st_d.pll_on = 1'b0;
      st_d.sw = SRC_FAST_RC;
      st_d.sws = SRC_FAST_RC;
      st_d.ahb = '0;
      st_d.low_speed_apb = '0;
      st_d.high_speed_apb = '0;
      st_d.adc = '0;
      st_d.osc_rdyf = 1'b0;
      st_d.osc_rdyie = 1'b0;
      st_d.irq = 1'b0;
      st_d.slow_rc_on = 1'b0;
      st_d.ent_stop = 1'b0;
      st_d.ent_stby = 1'b0;
    end

    st_d.bkp_rst_n = ~(st_q.bd_rst | st_q.bkp_lost_b);
    if (st_q.bkp_lost_b) begin
      st_d.xtal_on = 1'b0;
      st_d.rtc_sel = '0;
      st_d.bd_rst = 1'b0;
    end else if (st_q.bd_rst) begin
      st_d.xtal_on = 1'b0;
      st_d.rtc_sel = '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
      st_q.rst <= RS_PULSE;
      // The first edge after release wraps the count to zero, so the power-on pulse is full length.
      st_q.rcnt <= '1;
      st_q.rc_on <= 1'b1;
      st_q.flags <= 6'h02;
      st_q.sa <= '1;
      st_q.sb <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_apb = st_q.rsp;
  assign o_ext_reset_pin_n_o = 1'b0;
  assign o_ext_reset_pin_n_oe = st_q.pin_oe;
  assign o_sys_reset_n = st_q.sys_rst_n;
  assign o_backup_reset_n = st_q.bkp_rst_n;
  assign o_reset_vector = RESET_VECTOR;
  assign o_enter_stop = st_q.ent_stop;
  assign o_enter_standby = st_q.ent_stby;
  assign o_fast_rc_enable = st_q.rc_on;
  assign o_fast_osc_enable = st_q.osc_on;
  assign o_fast_osc_bypass = st_q.osc_byp;
  assign o_fast_osc_release = st_q.osc_rdy_prev;
  assign o_pll_enable = st_q.pll_on;
  assign o_slow_rc_enable = st_q.slow_rc_on;
  assign o_slow_crystal_enable = st_q.xtal_on;
  assign o_rtc_clock_sel = st_q.rtc_sel;
  assign o_system_clock_sel = st_q.sws;
  assign o_flash_iface_clock_en = st_q.rc_on;
  assign o_ticks = st_q.tk;
  assign o_clock_irq = st_q.irq;

endmodule : rcc_ctrl
`default_nettype wire

/* File: tb/rcc_ext_party.sv */
`timescale 1ns/1ps
`default_nettype none
module rcc_ext_party #(
  parameter logic [7:0] STARTUP = 8'h28
) (
  // Clock.
  input wire logic i_mclk,
  // Reset pin side.
  input wire logic i_pin_oe,
  input wire logic i_push_low,
  output logic o_pin_n,
  // Oscillator side.
  input wire logic i_osc_on,
  input wire logic i_bypass,
  output logic o_osc_stable
);
  logic [7:0] cnt_q;
  // The pin has a pull-up, so it reads high whenever no party pulls it down.
  assign o_pin_n = !(i_pin_oe || i_push_low);
  always_ff @(posedge i_mclk) begin
    if (!i_osc_on) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // A bypassed source already runs, so it settles far sooner than a crystal.
  assign o_osc_stable = i_osc_on && (cnt_q >= (i_bypass ? 8'h02 : STARTUP));
endmodule : rcc_ext_party
`default_nettype wire

/* File: tb/rcc_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl_sva
  import rcc_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Reset sources.
  input wire logic i_window_watchdog_rst,
  input wire logic i_independent_watchdog_rst,
  input wire logic i_core_sw_reset_request,
  input wire logic i_stop_entry,
  input wire logic i_stop_reset_option,
  input wire logic i_power_on_down_detect,
  input wire logic i_backup_power_lost,
  // Oscillator status.
  input wire logic i_fast_osc_stable,
  // Watched outputs.
  input wire logic o_ext_reset_pin_n_oe,
  input wire logic o_sys_reset_n,
  input wire logic o_backup_reset_n,
  input wire logic [31:0] o_reset_vector,
  input wire logic o_enter_stop,
  input wire logic o_fast_osc_enable,
  input wire logic o_fast_osc_release,
  input wire logic [1:0] o_system_clock_sel
);
  logic [8:0] oe_cnt_q;
  logic src;
  assign src = i_window_watchdog_rst || i_independent_watchdog_rst || i_core_sw_reset_request
    || (i_stop_entry && !i_stop_reset_option);
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_cnt_q <= 9'h000;
    end else begin
      oe_cnt_q <= o_ext_reset_pin_n_oe ? oe_cnt_q + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence s_pin_pulled;
    ##[1:3] o_ext_reset_pin_n_oe;
  endsequence
  chk_vector_fixed: assert property (o_reset_vector == RESET_VECTOR)
    else $error("reset vector wrong");
  chk_pulse_length: assert property ($fell(o_ext_reset_pin_n_oe) |-> oe_cnt_q >= 9'h0C8)
    else $error("reset pulse short");
  chk_pin_in_reset: assert property (o_ext_reset_pin_n_oe |-> !o_sys_reset_n)
    else $error("pin low outside reset");
  chk_source_pulls: assert property (src && o_sys_reset_n |-> s_pin_pulled)
    else $error("source not on pin");
  chk_stop_mode: assert property (i_stop_entry && i_stop_reset_option && o_sys_reset_n
    |-> ##[1:2] o_enter_stop)
    else $error("stop entry lost");
  chk_clk_default: assert property ($rose(o_sys_reset_n) |-> o_system_clock_sel == SRC_FAST_RC)
    else $error("clock not fast rc");
  chk_osc_sel_on: assert property (o_system_clock_sel == SRC_FAST_OSC |-> o_fast_osc_enable)
    else $error("osc selected while off");
  chk_osc_gated: assert property (o_fast_osc_release |->
    $past(o_fast_osc_enable) && $past(i_fast_osc_stable, 3))
    else $error("osc released while off");
  chk_power_reset: assert property (i_power_on_down_detect |-> ##[1:6] !o_sys_reset_n)
    else $error("power reset missed");
  chk_backup_reset: assert property (i_backup_power_lost |-> ##[1:6] !o_backup_reset_n)
    else $error("backup reset missed");
endmodule : rcc_ctrl_sva
`default_nettype wire

/* File: tb/reset_and_clock_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module reset_and_clock_control_tb
  import rcc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [4:0] src = '0;
  logic [1:0] opt = 2'h3;
  logic [1:0] pwr = '0;
  logic bk_lost = 1'b0;
  logic push_low = 1'b0;
  logic pin_n, oe, sys_n, bk_n, osc_on, byp, osc_ok, rel, irq, en_stop, en_stby, err;
  logic [1:0] sel;
  logic [31:0] rd;
  ticks_t tk;
  wire logic [7:0] obs;
  int error_cnt = 0;
  int n_tests = 0;
  int n_stop = 0;
  int n_stby = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    n_stop += en_stop;
    n_stby += en_stby;
  end
  rcc_ctrl uut (.i_mclk(clk), .i_arst_n(rst_n), .i_apb(req), .o_apb(rsp),
    .i_ext_reset_pin_n(pin_n), .o_ext_reset_pin_n_o(obs[7]), .o_ext_reset_pin_n_oe(oe),
    .i_window_watchdog_rst(src[0]), .i_independent_watchdog_rst(src[1]),
    .i_core_sw_reset_request(src[2]), .i_stop_entry(src[3]), .i_standby_entry(src[4]),
    .i_standby_reset_option(opt[0]), .i_stop_reset_option(opt[1]),
    .i_power_on_down_detect(pwr[0]), .i_standby_exit(pwr[1]), .i_backup_power_lost(bk_lost),
    .i_fast_osc_stable(osc_ok), .i_fast_rc_stable(1'b1), .i_pll_lock(1'b0),
    .i_slow_rc_stable(1'b1), .i_slow_crystal_stable(1'b1), .o_sys_reset_n(sys_n),
    .o_backup_reset_n(bk_n), .o_reset_vector(), .o_enter_stop(en_stop),
    .o_enter_standby(en_stby), .o_fast_rc_enable(obs[6]), .o_fast_osc_enable(osc_on),
    .o_fast_osc_bypass(byp), .o_fast_osc_release(rel), .o_pll_enable(obs[4]),
    .o_slow_rc_enable(obs[3]), .o_slow_crystal_enable(obs[2]), .o_rtc_clock_sel(obs[1:0]),
    .o_system_clock_sel(sel), .o_flash_iface_clock_en(obs[5]), .o_ticks(tk), .o_clock_irq(irq));
  rcc_ext_party party (.i_mclk(clk), .i_pin_oe(oe), .i_push_low(push_low), .o_pin_n(pin_n),
    .i_osc_on(osc_on), .i_bypass(byp), .o_osc_stable(osc_ok));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Starts on a fresh edge so the release of the previous transfer never collides.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wait_sys();
    while (sys_n !== 1'b1) begin
      @(posedge clk);
    end
  endtask : wait_sys
  task automatic t_por();
    wait_sys();
    apb(0, OFS_CLK_CTRL, 0);
    `CHK(rd, 32'h0000_0003)
    apb(0, OFS_CLK_CFG, 0);
    `CHK(rd, 32'h0000_0000)
    apb(0, OFS_CTRL_STAT, 0);
    `CHK(rd[31:26], 6'h02)
    apb(0, 12'h014, 0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    `CHK(obs, 8'h60)
    $display("por done");
  endtask : t_por
  task automatic t_int();
    int flag [5] = '{FL_WINDOW_WATCHDOG, FL_INDEPENDENT_WATCHDOG, FL_SW, FL_LPWR, FL_LPWR};
    opt <= 2'h0;
    apb(1, OFS_BKP_CTRL, 32'h0000_0100);
    for (int i = 0; i < 5; i++) begin
      apb(1, OFS_CTRL_STAT, 32'h0100_0000);
      apb(1, OFS_CLK_CFG, 32'h0000_0010);
      @(posedge clk);
      src <= 5'h01 << i;
      @(posedge clk);
      src <= 5'h00;
      cyc(3);
      `CHK({oe, sys_n}, 2'h2)
      cyc(190);
      `CHK(oe, 1'b1)
      wait_sys();
      apb(0, OFS_CTRL_STAT, 0);
      `CHK(rd[31:26], 6'h01 << flag[i])
      apb(0, OFS_CLK_CFG, 0);
      `CHK(rd[15:0], 16'h0000)
      apb(0, OFS_BKP_CTRL, 0);
      `CHK(rd, 32'h0000_0100)
      `CHK(obs[1:0], 2'h1)
    end
    opt <= 2'h3;
    $display("internal done");
  endtask : t_int
  task automatic t_ext();
    apb(1, OFS_CTRL_STAT, 32'h0100_0000);
    push_low <= 1'b1;
    cyc(300);
    `CHK(sys_n, 1'b0)
    push_low <= 1'b0;
    wait_sys();
    apb(0, OFS_CTRL_STAT, 0);
    `CHK(rd[31:26], 6'h01)
    @(posedge clk);
    src <= 5'h08;
    @(posedge clk);
    src <= 5'h10;
    @(posedge clk);
    src <= 5'h00;
    cyc(5);
    `CHK({n_stop, n_stby, sys_n}, {32'd1, 32'd1, 1'b1})
    $display("pin and mode done");
  endtask : t_ext
  task automatic t_osc();
    apb(1, OFS_CLK_IRQ, 32'h0000_0800);
    apb(1, OFS_CLK_CTRL, 32'h0001_0001);
    apb(1, OFS_CLK_CFG, 32'h0000_0001);
    apb(0, OFS_CLK_CFG, 0);
    `CHK({rd[3:2], irq}, {SRC_FAST_RC, 1'b0})
    while (rel !== 1'b1) begin
      @(posedge clk);
    end
    cyc(3);
    `CHK({sel, irq}, {SRC_FAST_OSC, 1'b1})
    apb(1, OFS_CLK_CTRL, 32'h0000_0001);
    apb(0, OFS_CLK_CTRL, 0);
    `CHK(rd[17:16], 2'h3)
    apb(1, OFS_CLK_IRQ, 32'h0008_0800);
    cyc(2);
    `CHK(irq, 1'b0)
    apb(1, OFS_CLK_CFG, 0);
    apb(1, OFS_CLK_CTRL, 32'h0000_0001);
    apb(0, OFS_CLK_CTRL, 0);
    `CHK({rd[17:16], osc_on}, 3'h0)
    apb(1, OFS_CLK_CTRL, 32'h0005_0001);
    cyc(12);
    `CHK({byp, rel}, 2'h3)
    apb(1, OFS_CTRL_STAT, 32'h0000_0001);
    apb(1, OFS_BKP_CTRL, 32'h0000_0001);
    apb(1, OFS_CLK_CTRL, 32'h0100_0001);
    apb(1, OFS_CLK_CFG, 32'h0000_0002);
    cyc(10);
    `CHK({sel, obs[4:2]}, {SRC_FAST_RC, 3'h7})
    apb(1, OFS_CLK_CFG, 0);
    apb(1, OFS_CLK_CTRL, 32'h0000_0001);
    $display("oscillator done");
  endtask : t_osc
  // Each tick period divides the window, so counts do not depend on phase.
  task automatic t_ticks(input logic [31:0] cfg, input int e [7]);
    int c [7];
    apb(1, OFS_CLK_CFG, cfg);
    cyc(20);
    c = '{0, 0, 0, 0, 0, 0, 0};
    repeat (80) begin
      @(posedge clk);
      c[0] += tk.ahb;
      c[1] += tk.high_speed_apb;
      c[2] += tk.tim2;
      c[3] += tk.system_tick_timer;
      c[4] += tk.adc;
      c[5] += tk.tim1;
      c[6] += tk.low_speed_apb;
    end
    for (int j = 0; j < 7; j++) `CHK(c[j], e[j])
    $display("ticks done");
  endtask : t_ticks
  task automatic t_power();
    for (int i = 0; i < 2; i++) begin
      apb(1, OFS_CTRL_STAT, 32'h0100_0000);
      apb(1, OFS_BKP_CTRL, 32'h0000_0100);
      pwr <= 2'h1 << i;
      cyc(5);
      pwr <= 2'h0;
      cyc(3);
      `CHK(sys_n, 1'b0)
      wait_sys();
      apb(0, OFS_CTRL_STAT, 0);
      `CHK(rd[31:26], 6'h02)
      apb(0, OFS_BKP_CTRL, 0);
      `CHK(rd, 32'h0000_0100)
    end
    bk_lost <= 1'b1;
    cyc(5);
    bk_lost <= 1'b0;
    cyc(5);
    apb(0, OFS_BKP_CTRL, 0);
    `CHK(rd, 32'h0000_0000)
    apb(1, OFS_BKP_CTRL, 32'h0001_0000);
    cyc(2);
    `CHK(bk_n, 1'b0)
    apb(1, OFS_BKP_CTRL, 32'h0000_0000);
    cyc(2);
    `CHK(bk_n, 1'b1)
    $display("power done");
  endtask : t_power
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    t_por();
    t_int();
    t_ext();
    t_osc();
    t_ticks(32'h0000_0000, '{80, 80, 80, 10, 40, 80, 80});
    t_ticks(32'h0000_C900, '{80, 40, 80, 10, 5, 80, 40});
    t_ticks(32'h0000_0010, '{40, 40, 40, 5, 20, 40, 40});
    apb(1, OFS_CLK_CFG, 0);
    t_power();
    report_and_stop();
  end
  initial begin
    cyc(30000);
    error_cnt++;
    report_and_stop();
  end
endmodule : reset_and_clock_control_tb
bind rcc_ctrl rcc_ctrl_sva chk (.i_mclk, .i_arst_n, .i_window_watchdog_rst,
  .i_independent_watchdog_rst, .i_core_sw_reset_request, .i_stop_entry, .i_stop_reset_option,
  .i_power_on_down_detect, .i_backup_power_lost, .o_ext_reset_pin_n_oe, .o_sys_reset_n,
  .o_backup_reset_n, .o_reset_vector, .o_enter_stop, .o_fast_osc_enable, .o_fast_osc_release,
  .o_system_clock_sel, .i_fast_osc_stable);
`default_nettype wire
